// ---- rtl/msbc_pkg.sv ----
package msbc_pkg;

    // =========================================================
    // timing
    localparam int CLOCK_MHZ = 20;
    localparam int RESET_MIN_NS = 10000;
    localparam int INIT_NS = 2000000;
    localparam int MGMT_MAX_KHZ = 400;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * CLOCK_MHZ + 999) / 1000;
    localparam int INIT_CYCLES = (INIT_NS * CLOCK_MHZ + 999) / 1000;

    // =========================================================
    // bus register offsets and fields
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_MASK = 8'h04;
    localparam logic [7:0] ADR_PINS = 8'h08;
    localparam logic [7:0] ADR_ALERT = 8'h0C;
    localparam logic [7:0] ADR_CONFIG = 8'h10;
    localparam int EV_WIDTH = 4;
    localparam int EV_RESET_DONE = 0;
    localparam int EV_HOST_RESET = 1;
    localparam int EV_MGMT_WRITE = 2;
    localparam int EV_LOWPOWER = 3;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam int PIN_SELECT_N = 0;
    localparam int PIN_RESET_N = 1;
    localparam int PIN_LOWPOWER = 2;
    localparam int PIN_INIT_PENDING = 3;
    localparam int PIN_INTERRUPT = 4;

    // =========================================================
    // management map seen by the host
    localparam logic [6:0] MGMT_DEV_ADDR = 7'h50;
    localparam logic [7:0] MGMT_STATUS = 8'h00;
    localparam logic [7:0] MGMT_FLAGS = 8'h01;
    localparam logic [7:0] MGMT_CONFIG = 8'h02;
    localparam int FLAG_RESET_DONE = 0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // =========================================================
    // state types
    typedef enum logic [1:0] {
        RS_INIT = 2'b00,
        RS_READY = 2'b01,
        RS_HELD = 2'b10
    } msbc_rst_state_type;

    typedef enum logic [2:0] {
        MT_IDLE = 3'b000,
        MT_ADDR = 3'b001,
        MT_ACK = 3'b010,
        MT_WRITE = 3'b011,
        MT_READ = 3'b100,
        MT_RACK = 3'b101
    } msbc_mgmt_state_type;

endpackage

// ---- rtl/msbc_sync.sv ----
`timescale 1ns/1ps
module msbc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage;

    // =========================================================
    // two flip-flop synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            stage <= d;
            q <= stage;
        end
    end

endmodule

// ---- rtl/msbc_mgmt_target.sv ----
`timescale 1ns/1ps
module msbc_mgmt_target (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic enable,
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] rd_data,
    output logic [7:0] ptr,
    output logic [7:0] acc_addr,
    output logic [7:0] wr_data,
    output logic wr_stb,
    output logic rd_stb,
    output logic sda_oe
);

    msbc_pkg::msbc_mgmt_state_type state;
    logic scl_d;
    logic sda_d;
    logic [7:0] shreg;
    logic [3:0] bit_cnt;
    logic first;
    logic rw;

    // =========================================================
    // byte-level target engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= msbc_pkg::MT_IDLE;
            scl_d <= 1'h1;
            sda_d <= 1'h1;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            first <= 1'h0;
            rw <= 1'h0;
            ptr <= 8'h00;
            acc_addr <= 8'h00;
            wr_data <= 8'h00;
            wr_stb <= 1'h0;
            rd_stb <= 1'h0;
            sda_oe <= 1'h0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            wr_stb <= 1'h0;
            rd_stb <= 1'h0;
            if (clear || !enable) begin
                state <= msbc_pkg::MT_IDLE;
                sda_oe <= 1'h0;
            end else if (scl && scl_d && sda_d && !sda) begin
                state <= msbc_pkg::MT_ADDR;
                bit_cnt <= 4'h0;
                first <= 1'h1;
                sda_oe <= 1'h0;
            end else if (scl && scl_d && !sda_d && sda) begin
                state <= msbc_pkg::MT_IDLE;
                sda_oe <= 1'h0;
            end else if (scl && !scl_d) begin
                case (state)
                    msbc_pkg::MT_ADDR, msbc_pkg::MT_WRITE: begin
                        shreg <= {shreg[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    msbc_pkg::MT_READ: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    msbc_pkg::MT_RACK: begin
                        state <= sda ? msbc_pkg::MT_IDLE : msbc_pkg::MT_ACK;
                    end
                    default: begin
                    end
                endcase
            end else if (!scl && scl_d) begin
                case (state)
                    msbc_pkg::MT_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shreg[7:1] == msbc_pkg::MGMT_DEV_ADDR) begin
                                sda_oe <= 1'h1;
                                rw <= shreg[0];
                                state <= msbc_pkg::MT_ACK;
                            end else begin
                                state <= msbc_pkg::MT_IDLE;
                            end
                        end
                    end
                    msbc_pkg::MT_WRITE: begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'h1;
                            state <= msbc_pkg::MT_ACK;
                            if (first) begin
                                ptr <= shreg;
                                first <= 1'h0;
                            end else begin
                                wr_stb <= 1'h1;
                                wr_data <= shreg;
                                acc_addr <= ptr;
                                ptr <= ptr + 8'h01;
                            end
                        end
                    end
                    msbc_pkg::MT_ACK: begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            shreg <= rd_data;
                            sda_oe <= ~rd_data[7];
                            rd_stb <= 1'h1;
                            acc_addr <= ptr;
                            ptr <= ptr + 8'h01;
                            state <= msbc_pkg::MT_READ;
                        end else begin
                            sda_oe <= 1'h0;
                            state <= msbc_pkg::MT_WRITE;
                        end
                    end
                    msbc_pkg::MT_READ: begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'h0;
                            state <= msbc_pkg::MT_RACK;
                        end else begin
                            sda_oe <= ~shreg[3'(4'h7 - bit_cnt)];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule

// ---- rtl/msbc_sideband.sv ----
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - select low lets the module answer management bus commands.
// - select high makes the module ignore all management traffic.
// - select pin has an internal pull-up, undriven means deselected.
// - reset pin has an internal pull-up, undriven means not reset.
// - reset low past minimum width restores all user settings to default.
// - reset-completion interval starts at the reset pin rising edge.
// - completion shown by interrupt with initialisation-pending bit clear.
// - power-up posts the completion interrupt with no reset pulse.
// - low-power request high enters reduced power mode.
// - presence pin grounded inside, pulled high by host.
// - interrupt pin driven low for faults or critical status.
// - interrupt pin only pulls low; host supplies pull-up.
module msbc_sideband #(
    parameter int RESET_MIN_CYCLES = msbc_pkg::RESET_MIN_CYCLES,
    parameter int INIT_CYCLES = msbc_pkg::INIT_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ,
    input wire logic MODULE_SELECT_N,
    output logic MODULE_SELECT_PULLUP,
    input wire logic MODULE_RESET_N,
    output logic MODULE_RESET_PULLUP,
    input wire logic LOW_POWER_REQUEST,
    output logic LOW_POWER_MODE,
    output logic INIT_PENDING,
    output logic MODULE_PRESENT_N_O,
    output logic MODULE_PRESENT_N_OE,
    output logic INTERRUPT_N_O,
    output logic INTERRUPT_N_OE,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE
);

    // =========================================================
    // pin synchronisers
    logic [4:0] pins_raw;
    logic [4:0] pins_s;

    logic select_n_s;
    logic reset_n_s;
    logic lowpower_s;
    logic scl_s;
    logic sda_s;

    assign pins_raw = {SDA_I, SCL, LOW_POWER_REQUEST, MODULE_RESET_N, MODULE_SELECT_N};
    assign select_n_s = pins_s[0];
    assign reset_n_s = pins_s[1];
    assign lowpower_s = pins_s[2];
    assign scl_s = pins_s[3];
    assign sda_s = pins_s[4];

    // idle value of select is deselected
    // idle value of reset is released
    msbc_sync #(
        .WIDTH(5),
        .RESET_VAL(5'h1B)
    ) msbc_sync_i (
        .clk(CLOCK),
        .rst_n(RST_B),
        .d(pins_raw),
        .q(pins_s)
    );

    // =========================================================
    // fixed pin drivers
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            MODULE_SELECT_PULLUP <= 1'h1;
            MODULE_RESET_PULLUP <= 1'h1;
            MODULE_PRESENT_N_O <= 1'h0;
            MODULE_PRESENT_N_OE <= 1'h1;
            INTERRUPT_N_O <= 1'h0;
            SDA_O <= 1'h0;
        end else begin
            MODULE_SELECT_PULLUP <= 1'h1;
            MODULE_RESET_PULLUP <= 1'h1;
            MODULE_PRESENT_N_O <= 1'h0;
            MODULE_PRESENT_N_OE <= 1'h1;
            INTERRUPT_N_O <= 1'h0;
            SDA_O <= 1'h0;
        end
    end

    // =========================================================
    // module reset sequencing
    msbc_pkg::msbc_rst_state_type rst_state;
    logic [23:0] low_cnt;
    logic [23:0] init_cnt;

    logic reset_n_d;
    logic long_low;
    logic init_done;
    logic held;

    assign long_low = (low_cnt >= 24'(RESET_MIN_CYCLES));
    assign init_done = (rst_state == msbc_pkg::RS_INIT) && (init_cnt >= 24'(INIT_CYCLES - 1));
    assign held = (rst_state == msbc_pkg::RS_HELD);

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            low_cnt <= 24'h000000;
            reset_n_d <= 1'h1;
        end else begin
            reset_n_d <= reset_n_s;
            if (reset_n_s) begin
                low_cnt <= 24'h000000;
            end else if (!long_low) begin
                low_cnt <= low_cnt + 24'h000001;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_state <= msbc_pkg::RS_INIT;
            init_cnt <= 24'h000000;
        end else begin
            case (rst_state)
                msbc_pkg::RS_INIT: begin
                    init_cnt <= init_cnt + 24'h000001;
                    if (long_low) begin
                        rst_state <= msbc_pkg::RS_HELD;
                    end else if (init_done) begin
                        rst_state <= msbc_pkg::RS_READY;
                    end
                end
                msbc_pkg::RS_READY: begin
                    if (long_low) begin
                        rst_state <= msbc_pkg::RS_HELD;
                    end
                end
                msbc_pkg::RS_HELD: begin
                    if (reset_n_s && !reset_n_d) begin
                        rst_state <= msbc_pkg::RS_INIT;
                        init_cnt <= 24'h000000;
                    end
                end
                default: begin
                    rst_state <= msbc_pkg::RS_INIT;
                    init_cnt <= 24'h000000;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            INIT_PENDING <= 1'h1;
        end else begin
            INIT_PENDING <= (rst_state != msbc_pkg::RS_READY) && !init_done;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            LOW_POWER_MODE <= 1'h0;
        end else begin
            LOW_POWER_MODE <= lowpower_s;
        end
    end

    // =========================================================
    // management target and host map
    logic [7:0] mt_ptr;
    logic [7:0] mt_acc_addr;
    logic [7:0] mt_wr_data;
    logic mt_wr_stb;
    logic mt_rd_stb;
    logic [7:0] mt_rd_data;

    logic [7:0] host_flags;
    logic [7:0] user_config;
    logic [7:0] alert_set;

    msbc_mgmt_target msbc_mgmt_target_i (
        .clk(CLOCK),
        .rst_n(RST_B),
        .clear(held),
        .enable(!select_n_s),
        .scl(scl_s),
        .sda(sda_s),
        .rd_data(mt_rd_data),
        .ptr(mt_ptr),
        .acc_addr(mt_acc_addr),
        .wr_data(mt_wr_data),
        .wr_stb(mt_wr_stb),
        .rd_stb(mt_rd_stb),
        .sda_oe(SDA_OE)
    );

    always_comb begin
        case (mt_ptr)
            msbc_pkg::MGMT_STATUS: mt_rd_data = {7'h00, INIT_PENDING};
            msbc_pkg::MGMT_FLAGS: mt_rd_data = host_flags;
            msbc_pkg::MGMT_CONFIG: mt_rd_data = user_config;
            default: mt_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            user_config <= msbc_pkg::CONFIG_RESET;
        end else if (held) begin
            user_config <= msbc_pkg::CONFIG_RESET;
        end else if (mt_wr_stb && mt_acc_addr == msbc_pkg::MGMT_CONFIG) begin
            user_config <= mt_wr_data;
        end
    end

    logic [7:0] next_host_flags;

    always_comb begin
        next_host_flags = host_flags | alert_set;
        if (mt_rd_stb && mt_acc_addr == msbc_pkg::MGMT_FLAGS) begin
            next_host_flags = alert_set;
        end
        if (init_done) begin
            next_host_flags[msbc_pkg::FLAG_RESET_DONE] = 1'h1;
        end
    end

    // flags cleared by host read, set wins
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            host_flags <= 8'h00;
        end else if (held) begin
            host_flags <= 8'h00;
        end else begin
            host_flags <= next_host_flags;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            INTERRUPT_N_OE <= 1'h0;
        end else begin
            INTERRUPT_N_OE <= |host_flags;
        end
    end

    // =========================================================
    // wishbone slave
    logic wb_req;
    logic wb_wr;
    logic [3:0] status;
    logic [3:0] mask;
    logic [3:0] events;

    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
    assign alert_set = (wb_wr && WB_ADR_I == msbc_pkg::ADR_ALERT) ? (WB_DAT_I[7:0] & 8'hFE) : 8'h00;

    always_comb begin
        events = 4'h0;
        events[msbc_pkg::EV_RESET_DONE] = init_done;
        events[msbc_pkg::EV_HOST_RESET] = long_low && (rst_state != msbc_pkg::RS_HELD);
        events[msbc_pkg::EV_MGMT_WRITE] = mt_wr_stb;
        events[msbc_pkg::EV_LOWPOWER] = LOW_POWER_MODE != lowpower_s;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            WB_ACK_O <= 1'h0;
        end else begin
            WB_ACK_O <= wb_req;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            WB_DAT_O <= 32'h00000000;
        end else if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
                msbc_pkg::ADR_STATUS: WB_DAT_O <= {28'h0000000, status};
                msbc_pkg::ADR_MASK: WB_DAT_O <= {28'h0000000, mask};
                msbc_pkg::ADR_PINS: WB_DAT_O <= {27'h0000000, INTERRUPT_N_OE, INIT_PENDING, LOW_POWER_MODE,
                    reset_n_s, select_n_s};
                msbc_pkg::ADR_ALERT: WB_DAT_O <= {24'h000000, host_flags};
                msbc_pkg::ADR_CONFIG: WB_DAT_O <= {24'h000000, user_config};
                default: WB_DAT_O <= 32'h00000000;
            endcase
        end
    end

    // event status: write one clears, set wins
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            status <= msbc_pkg::STATUS_RESET;
        end else if (wb_wr && WB_ADR_I == msbc_pkg::ADR_STATUS) begin
            status <= (status & ~WB_DAT_I[3:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            mask <= msbc_pkg::MASK_RESET;
        end else if (wb_wr && WB_ADR_I == msbc_pkg::ADR_MASK) begin
            mask <= WB_DAT_I[3:0];
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ <= 1'h0;
        end else begin
            IRQ <= |(status & mask);
        end
    end

endmodule

// ---- sim/msbc_sideband_asserts.sv ----
`timescale 1ns/1ps
module msbc_sideband_asserts #(
    parameter int RESET_MIN_CYCLES = 4,
    parameter int INIT_CYCLES = 20
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic MODULE_SELECT_N,
    input wire logic MODULE_SELECT_PULLUP,
    input wire logic MODULE_RESET_N,
    input wire logic MODULE_RESET_PULLUP,
    input wire logic LOW_POWER_REQUEST,
    input wire logic LOW_POWER_MODE,
    input wire logic INIT_PENDING,
    input wire logic MODULE_PRESENT_N_O,
    input wire logic MODULE_PRESENT_N_OE,
    input wire logic INTERRUPT_N_O,
    input wire logic INTERRUPT_N_OE,
    input wire logic SDA_OE
);
    // =========================================================
    // cycles the reset pin has been low
    int low_cnt;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B)
            low_cnt <= 0;
        else if (MODULE_RESET_N)
            low_cnt <= 0;
        else if (low_cnt < 1000)
            low_cnt <= low_cnt + 1;
    end
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    // =========================================================
    // properties
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("no ack after request");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    select_pullup_a: assert property (MODULE_SELECT_PULLUP)
        else $error("select pull-up off");
    reset_pullup_a: assert property (MODULE_RESET_PULLUP)
        else $error("reset pull-up off");
    presence_ground_a: assert property (MODULE_PRESENT_N_OE && !MODULE_PRESENT_N_O)
        else $error("presence pin not grounded");
    int_pull_low_a: assert property (!INTERRUPT_N_O)
        else $error("interrupt pin driven high");
    deselect_quiet_a: assert property (MODULE_SELECT_N [*4] |-> !SDA_OE)
        else $error("data line driven while deselected");
    lowpower_on_a: assert property (LOW_POWER_REQUEST [*4] |-> LOW_POWER_MODE)
        else $error("low power mode not entered");
    lowpower_off_a: assert property (!LOW_POWER_REQUEST [*4] |-> !LOW_POWER_MODE)
        else $error("low power mode not left");
    done_irq_a: assert property ($fell(INIT_PENDING) |-> ##[1:2] INTERRUPT_N_OE)
        else $error("no interrupt at reset completion");
    long_reset_a: assert property (low_cnt >= RESET_MIN_CYCLES + 6 |-> INIT_PENDING)
        else $error("long reset pulse not taken");
endmodule

bind msbc_sideband msbc_sideband_asserts #(
    .RESET_MIN_CYCLES(RESET_MIN_CYCLES),
    .INIT_CYCLES(INIT_CYCLES)
) msbc_sideband_asserts_i (.*);

// ---- sim/msbc_host_model.sv ----
`timescale 1ns/1ps
module msbc_host_model (
    input wire logic sda_oe,
    input wire logic sda_o,
    input wire logic int_oe,
    input wire logic int_o,
    input wire logic prs_o,
    input wire logic prs_oe,
    output logic scl,
    output logic sda,
    output logic int_n,
    output logic prs_n
);
    // =========================================================
    // board wiring with pull-ups
    localparam int H = 1250;
    logic low = 1'h0;
    assign int_n = ~(int_oe & ~int_o);
    assign prs_n = prs_oe ? prs_o : 1'h1;
    assign sda = ~(low | (sda_oe & ~sda_o));
    initial scl = 1'h1;
    // =========================================================
    // serial clock 400 kHz
    task automatic start();
        #7 low = 1'h0;
        #H scl = 1'h1;
        #H low = 1'h1;
        #H scl = 1'h0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(H/2) low = ~b[i];
            #(H/2) scl = 1'h1;
            #H scl = 1'h0;
        end
        #(H/2) low = 1'h0;
        #(H/2) scl = 1'h1;
        #(H/2) ack = ~sda;
        #(H/2) scl = 1'h0;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #H scl = 1'h1;
            #(H/2) b[i] = sda;
            #(H/2) scl = 1'h0;
        end
        #(H/2) low = ~nack;
        #(H/2) scl = 1'h1;
        #H scl = 1'h0;
    endtask
    task automatic stop();
        #(H/2) low = 1'h1;
        #(H/2) scl = 1'h1;
        #H low = 1'h0;
        #H;
    endtask
endmodule

// ---- sim/msbc_sideband_test.sv ----
`timescale 1ns/1ps
module msbc_sideband_test;
    localparam int INIT_T = 20;
    localparam int RMIN_T = 4;
    localparam logic [7:0] DW = {msbc_pkg::MGMT_DEV_ADDR, 1'h0};
    localparam logic [7:0] DR = {msbc_pkg::MGMT_DEV_ADDR, 1'h1};
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic req = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic sel_en = 1'h0;
    logic rst_en = 1'h0;
    logic lp = 1'h0;
    logic [31:0] rdat, q;
    logic ack, sel_pu, rst_pu, sda_oe, sda_o, int_o, int_oe, prs_o, prs_oe, scl, sda, int_n, prs_n;
    logic irq, lpm, initp, sel_n, rst_n;
    int n_mismatch = 0;
    int num_checks = 0;
    assign sel_n = sel_en ? 1'h0 : sel_pu;
    assign rst_n = rst_en ? 1'h0 : rst_pu;
    always #25 clock = ~clock;
    msbc_sideband #(.RESET_MIN_CYCLES(RMIN_T), .INIT_CYCLES(INIT_T)) msbc_sideband_i (
        .CLOCK(clock), .RST_B(rst_b), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq),
        .MODULE_SELECT_N(sel_n), .MODULE_SELECT_PULLUP(sel_pu), .MODULE_RESET_N(rst_n),
        .MODULE_RESET_PULLUP(rst_pu), .LOW_POWER_REQUEST(lp), .LOW_POWER_MODE(lpm), .INIT_PENDING(initp),
        .MODULE_PRESENT_N_O(prs_o), .MODULE_PRESENT_N_OE(prs_oe), .INTERRUPT_N_O(int_o),
        .INTERRUPT_N_OE(int_oe), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe));
    msbc_host_model host_i (.sda_oe(sda_oe), .sda_o(sda_o), .int_oe(int_oe), .int_o(int_o),
        .prs_o(prs_o), .prs_oe(prs_oe), .scl(scl), .sda(sda), .int_n(int_n), .prs_n(prs_n));
    // =========================================================
    // shared tasks
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock);
        req <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'h1 && n < 50);
        r = rdat;
        req <= 1'h0;
        if (n >= 50) begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic wait_init(output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (initp !== 1'h0 && n < 200);
        chk(n >= INIT_T && n <= INIT_T + 8, 1'h1);
        if (n >= 200)
            summarize();
    endtask
    // =========================================================
    // scenarios
    task automatic t_power();
        int n;
        wait_init(n);
        tick(2);
        chk(int_n, 1'h0);
        chk(prs_n, 1'h0);
        wb(1'h0, msbc_pkg::ADR_STATUS, 32'h0, q);
        chk(q, 32'h1);
        chk(irq, 1'h0);
    endtask
    task automatic t_irq();
        wb(1'h1, msbc_pkg::ADR_MASK, 32'h1, q);
        tick(2);
        chk(irq, 1'h1);
        wb(1'h1, msbc_pkg::ADR_STATUS, 32'h1, q);
        wb(1'h1, msbc_pkg::ADR_CONFIG, 32'hFF, q);
        chk(irq, 1'h0);
        wb(1'h0, msbc_pkg::ADR_STATUS, 32'h0, q);
        chk(q, 32'h0);
        wb(1'h0, 8'h20, 32'h0, q);
        chk(q, 32'h0);
        wb(1'h0, msbc_pkg::ADR_CONFIG, 32'h0, q);
        chk(q, 32'h0);
    endtask
    task automatic t_mgmt();
        logic a0, a1, a2;
        logic [7:0] b;
        @(posedge clock);
        sel_en <= 1'h1;
        tick(4);
        host_i.start();
        host_i.wbyte(DW, a0);
        host_i.wbyte(msbc_pkg::MGMT_FLAGS, a1);
        host_i.start();
        host_i.wbyte(DR, a2);
        host_i.rbyte(1'h1, b);
        host_i.stop();
        chk({a0, a1, a2}, 3'h7);
        chk(b, 8'h01);
        tick(3);
        chk(int_n, 1'h1);
        host_i.start();
        host_i.wbyte(DW, a0);
        host_i.wbyte(msbc_pkg::MGMT_CONFIG, a1);
        host_i.wbyte(8'h5A, a2);
        host_i.stop();
        wb(1'h0, msbc_pkg::ADR_CONFIG, 32'h0, q);
        chk(q, 32'h5A);
        wb(1'h0, msbc_pkg::ADR_STATUS, 32'h0, q);
        chk(q, 32'h4);
        wb(1'h1, msbc_pkg::ADR_ALERT, 32'h2, q);
        tick(3);
        chk(int_n, 1'h0);
    endtask
    task automatic t_desel();
        logic a0;
        @(posedge clock);
        sel_en <= 1'h0;
        tick(4);
        host_i.start();
        host_i.wbyte(DW, a0);
        host_i.stop();
        chk(a0, 1'h0);
        wb(1'h0, msbc_pkg::ADR_PINS, 32'h0, q);
        chk(q[0], 1'h1);
    endtask
    task automatic t_reset();
        int n;
        @(posedge clock);
        rst_en <= 1'h1;
        repeat (2) @(posedge clock);
        rst_en <= 1'h0;
        tick(10);
        wb(1'h0, msbc_pkg::ADR_CONFIG, 32'h0, q);
        chk(q, 32'h5A);
        @(posedge clock);
        rst_en <= 1'h1;
        tick(RMIN_T + 8);
        chk(initp, 1'h1);
        @(posedge clock);
        rst_en <= 1'h0;
        wait_init(n);
        tick(2);
        chk(int_n, 1'h0);
        wb(1'h0, msbc_pkg::ADR_CONFIG, 32'h0, q);
        chk(q, 32'h0);
        wb(1'h0, msbc_pkg::ADR_STATUS, 32'h0, q);
        chk(q, 32'h7);
        wb(1'h0, msbc_pkg::ADR_PINS, 32'h0, q);
        chk(q[1], 1'h1);
    endtask
    task automatic t_lowpower();
        @(posedge clock);
        lp <= 1'h1;
        tick(5);
        chk(lpm, 1'h1);
        wb(1'h0, msbc_pkg::ADR_STATUS, 32'h0, q);
        chk(q[3], 1'h1);
        @(posedge clock);
        lp <= 1'h0;
        tick(5);
        chk(lpm, 1'h0);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'h1;
        t_power();
        t_irq();
        t_mgmt();
        t_desel();
        t_reset();
        t_lowpower();
        summarize();
    end
endmodule
